// File: qrw_pkg.sv
// ====================================================================
// Opcodes, phase lengths and settings
package qrw_pkg;

  localparam logic [7:0] OP_QIO4    = 8'hEC;
  localparam logic [7:0] OP_WRAP    = 8'h1B;
  localparam logic [7:0] OP_QPI_EN  = 8'h38;
  localparam logic [7:0] OP_ENH_RST = 8'hFF;

  localparam logic [5:0] OP_BITS    = 6'h08;
  localparam logic [5:0] ADDR3_BITS = 6'h18;
  localparam logic [5:0] ADDR4_BITS = 6'h20;
  localparam logic [5:0] TX_MAX     = 6'h30;

  // Dummy clocks; quad read spends two of its six on the mode byte
  localparam logic [3:0] DUM_ENH    = 4'h4;
  localparam logic [3:0] DUM_WRAP_1 = 4'h8;
  localparam logic [3:0] DUM_WRAP_4 = 4'h6;

  // Wrap length code: window bytes are WLEN_BASE shifted by the code
  localparam logic [1:0] WLEN_RST   = 2'h0;
  localparam logic [7:0] WLEN_BASE  = 8'h08;

  localparam logic [31:0] ARRAY_TOP_DEF = 32'h01FF_FFFF;
  localparam int          HALF_DEF      = 4;
  localparam int          FIFO_W_DEF    = 8;
  localparam int          FIFO_D_DEF    = 8;

  typedef enum logic [2:0] {
    CMD_QIO,
    CMD_QIO_CONT,
    CMD_WRAP,
    CMD_QPI_EN,
    CMD_ENH_RST
  } qrw_cmd_e;

endpackage : qrw_pkg

// File: qrw_if.sv
`timescale 1ns/1ps
// ====================================================================
// Serial link between controller and flash; data lines idle high
interface qrw_if;
  logic       cs_n;
  logic       sclk;
  logic [3:0] h_dq;
  logic [3:0] h_oe_n;
  logic [3:0] d_dq;
  logic [3:0] d_oe_n;
  logic [3:0] io;

  assign io = (~d_oe_n & d_dq) | (d_oe_n & ~h_oe_n & h_dq)
            | (d_oe_n & h_oe_n);

  modport host (output cs_n, sclk, h_dq, h_oe_n, input io);
  modport dev  (input cs_n, sclk, io, output d_dq, d_oe_n);
endinterface : qrw_if

// File: qrw_fifo.sv
`timescale 1ns/1ps
// ====================================================================
// Read data buffer
module qrw_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_nrst,
  input  wire logic         i_ce,
  input  wire logic         i_valid,
  output logic              o_ready,
  input  wire logic [W-1:0] i_data,
  output logic              o_valid,
  input  wire logic         i_ready,
  output logic [W-1:0]      o_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam logic [AW:0]   DEPTH = (AW+1)'(D);
  localparam logic [AW-1:0] LAST  = AW'(D - 1);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } qrw_fst_s;

  qrw_fst_s     st_ff;
  qrw_fst_s     nxt_st;
  logic [W-1:0] mem_ff [D];
  logic         wr;
  logic         rd;

  assign o_ready = (st_ff.cnt != DEPTH);
  assign o_valid = (st_ff.cnt != '0);
  assign o_data  = mem_ff[st_ff.rp];
  assign wr      = i_valid & o_ready;
  assign rd      = o_valid & i_ready;

  always_comb begin
    nxt_st = st_ff;
    if (wr) begin
      nxt_st.wp = (st_ff.wp == LAST) ? '0 : st_ff.wp + 1'b1;
    end
    if (rd) begin
      nxt_st.rp = (st_ff.rp == LAST) ? '0 : st_ff.rp + 1'b1;
    end
    if (wr && !rd) begin
      nxt_st.cnt = st_ff.cnt + 1'b1;
    end else if (rd && !wr) begin
      nxt_st.cnt = st_ff.cnt - 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      st_ff <= '0;
    end else if (i_ce) begin
      st_ff <= nxt_st;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_ce && wr) begin
      mem_ff[st_ff.wp] <= i_data;
    end
  end
endmodule : qrw_fifo

// File: qrw_host.sv
`timescale 1ns/1ps
// ====================================================================
// Controller end: makes the serial clock, frames commands, buffers data
module qrw_host
  import qrw_pkg::*;
#(
  parameter int HALF   = HALF_DEF,
  parameter int FIFO_D = FIFO_D_DEF
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_nrst,
  input  wire logic        i_ce,
  input  wire logic        i_start,
  input  qrw_cmd_e         i_cmd,
  input  wire logic [31:0] i_addr,
  input  wire logic [7:0]  i_mode,
  input  wire logic [15:0] i_len,
  input  wire logic        i_addr4,
  output logic             o_busy,
  output logic             o_qpi,
  output logic             o_rx_valid,
  output logic [7:0]       o_rx_data,
  input  wire logic        i_rx_ready,
  qrw_if.host              bus
);
  localparam logic [7:0] HALF_LAST = 8'(HALF - 1);

  typedef enum logic [2:0] {
    H_IDLE, H_TX, H_DUMMY, H_RX, H_END, H_HOLD
  } qrw_hst_e;

  typedef struct packed {
    qrw_hst_e    st;
    logic [7:0]  div;
    logic        sclk;
    logic        csn;
    logic [47:0] sh;
    logic [5:0]  total;
    logic [5:0]  sent;
    logic        opw;
    logic        bw;
    logic        dw;
    logic [3:0]  nd;
    logic [15:0] len;
    logic [7:0]  rx;
    logic [2:0]  rxc;
    logic        push;
    logic [7:0]  pdata;
    logic        four_line_command_mode;
    logic [3:0]  dq;
    logic [3:0]  oe_n;
  } qrw_hst_s;

  qrw_hst_s   st_ff;
  qrw_hst_s   nxt_st;
  logic       f_ready;
  logic       tick;
  logic       wc;
  logic       wn;
  logic [5:0] step;
  logic [7:0] rxn;

  always_comb begin
    nxt_st = st_ff;
    tick = (st_ff.div == HALF_LAST);
    wc = (st_ff.sent < OP_BITS) ? st_ff.opw : st_ff.bw;
    step = wc ? 6'h04 : 6'h01;
    rxn = st_ff.dw ? {st_ff.rx[3:0], bus.io}
                   : {st_ff.rx[6:0], bus.io[1]};
    wn = 1'b0;
    nxt_st.push = 1'b0;
    // A full buffer holds the clock low before the next rising edge
    if (!(st_ff.st == H_RX && !st_ff.sclk && !f_ready)) begin
      nxt_st.div = tick ? 8'h00 : st_ff.div + 8'h01;
    end
    case (st_ff.st)
      H_IDLE: begin
        nxt_st.div = 8'h00;
        if (i_start) begin
          nxt_st.st = H_TX;
          nxt_st.csn = 1'b0;
          nxt_st.sent = 6'h00;
          nxt_st.total = TX_MAX;
          nxt_st.opw = st_ff.four_line_command_mode;
          nxt_st.bw = 1'b1;
          nxt_st.dw = 1'b1;
          nxt_st.nd = DUM_ENH;
          nxt_st.len = i_len;
          nxt_st.rxc = 3'h0;
          case (i_cmd)
            CMD_QIO: nxt_st.sh = {OP_QIO4, i_addr, i_mode};
            CMD_QIO_CONT: begin
              nxt_st.sh = {i_addr, i_mode, 8'h00};
              nxt_st.sent = OP_BITS;
            end
            CMD_WRAP: begin
              nxt_st.bw = st_ff.four_line_command_mode;
              nxt_st.dw = st_ff.four_line_command_mode;
              nxt_st.nd = st_ff.four_line_command_mode ? DUM_WRAP_4 : DUM_WRAP_1;
              nxt_st.sh = i_addr4 ? {OP_WRAP, i_addr, 8'h00}
                                  : {OP_WRAP, i_addr[23:0], 16'h0000};
              nxt_st.total = OP_BITS + (i_addr4 ? ADDR4_BITS : ADDR3_BITS);
            end
            CMD_QPI_EN: begin
              nxt_st.sh = {OP_QPI_EN, 40'h00_0000_0000};
              nxt_st.total = OP_BITS;
              nxt_st.nd = 4'h0;
              nxt_st.four_line_command_mode = 1'b1;
            end
            CMD_ENH_RST: begin
              nxt_st.sh = {OP_ENH_RST, 40'h00_0000_0000};
              nxt_st.total = OP_BITS;
              nxt_st.nd = 4'h0;
              nxt_st.opw = 1'b0;
            end
            default: nxt_st.st = H_IDLE;
          endcase
        end
      end
      H_TX: if (tick) begin
        nxt_st.sclk = ~st_ff.sclk;
        if (st_ff.sclk) begin
          if (st_ff.sent + step == st_ff.total) begin
            nxt_st.oe_n = 4'hF;
            nxt_st.st = (st_ff.nd != 4'h0) ? H_DUMMY : H_END;
          end else begin
            nxt_st.sent = st_ff.sent + step;
            nxt_st.sh = wc ? {st_ff.sh[43:0], 4'h0}
                           : {st_ff.sh[46:0], 1'b0};
          end
        end
      end
      H_DUMMY: if (tick) begin
        nxt_st.sclk = ~st_ff.sclk;
        if (st_ff.sclk) begin
          nxt_st.nd = st_ff.nd - 4'h1;
          if (st_ff.nd == 4'h1) begin
            nxt_st.st = (st_ff.len != 16'h0000) ? H_RX : H_END;
          end
        end
      end
      H_RX: if (tick) begin
        nxt_st.sclk = ~st_ff.sclk;
        if (!st_ff.sclk) begin
          nxt_st.rx = rxn;
          nxt_st.rxc = st_ff.rxc + (st_ff.dw ? 3'h4 : 3'h1);
          if (st_ff.rxc == (st_ff.dw ? 3'h4 : 3'h7)) begin
            nxt_st.push = 1'b1;
            nxt_st.pdata = rxn;
            nxt_st.len = st_ff.len - 16'h0001;
            if (st_ff.len == 16'h0001) begin
              nxt_st.st = H_END;
            end
          end
        end
      end
      H_END: if (tick) begin
        nxt_st.sclk = 1'b0;
        nxt_st.csn = 1'b1;
        nxt_st.oe_n = 4'hF;
        nxt_st.st = H_HOLD;
      end
      H_HOLD: if (tick) begin
        nxt_st.st = H_IDLE;
      end
      default: nxt_st.st = H_IDLE;
    endcase
    // Next bits go out while the clock is low, ahead of the rising edge
    if (nxt_st.st == H_TX) begin
      wn = (nxt_st.sent < OP_BITS) ? nxt_st.opw : nxt_st.bw;
      nxt_st.dq = wn ? nxt_st.sh[47:44] : {3'b111, nxt_st.sh[47]};
      nxt_st.oe_n = wn ? 4'h0 : 4'hE;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      st_ff <= '0;
      st_ff.csn <= 1'b1;
      st_ff.oe_n <= 4'hF;
    end else if (i_ce) begin
      st_ff <= nxt_st;
    end
  end

  qrw_fifo #(.W(FIFO_W_DEF), .D(FIFO_D)) u_fifo (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_ce      (i_ce),
    .i_valid   (st_ff.push),
    .o_ready   (f_ready),
    .i_data    (st_ff.pdata),
    .o_valid   (o_rx_valid),
    .i_ready   (i_rx_ready),
    .o_data    (o_rx_data)
  );

  assign bus.cs_n   = st_ff.csn;
  assign bus.sclk   = st_ff.sclk;
  assign bus.h_dq   = st_ff.dq;
  assign bus.h_oe_n = st_ff.oe_n;
  assign o_busy     = (st_ff.st != H_IDLE);
  assign o_qpi      = st_ff.four_line_command_mode;
endmodule : qrw_host

// File: qrw_dev.sv
`timescale 1ns/1ps

// ====================================================================
// Flash end: decodes the frame and streams array bytes
module qrw_dev
  import qrw_pkg::*;
#(
  parameter logic [31:0] ARRAY_TOP = ARRAY_TOP_DEF
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_nrst,
  input  wire logic        i_ce,
  qrw_if.dev               bus,
  input  wire logic        i_addr4,
  input  wire logic        i_busy,
  input  wire logic        i_wlen_we,
  input  wire logic [1:0]  i_wlen,
  input  wire logic [7:0]  i_mem_data,
  output logic [31:0]      o_mem_addr,
  output logic             o_qpi,
  output logic             o_enh,
  output logic [1:0]       o_wlen,
  output logic             o_active
);
  typedef enum logic [2:0] {
    D_IDLE, D_CMD, D_ADDR, D_MODE, D_DUMMY, D_DATA, D_IGNORE
  } qrw_dst_e;

  typedef struct packed {
    qrw_dst_e    st;
    logic        sclk_q;
    logic [31:0] sh;
    logic [5:0]  cnt;
    logic [31:0] addr;
    logic        quad;
    logic        wrap;
    logic        enh;
    logic        four_line_command_mode;
    logic [1:0]  wlen;
    logic [7:0]  dbyte;
    logic [2:0]  bitc;
    logic [3:0]  dq;
    logic [3:0]  oe_n;
  } qrw_dst_s;

  qrw_dst_s    st_ff;
  qrw_dst_s    nxt_st;
  logic        rise;
  logic        fall;
  logic        w4;
  logic [5:0]  cnt_n;
  logic [5:0]  abits;
  logic [3:0]  ndum;
  logic [31:0] shv;
  logic [7:0]  bval;

  // ==================================================================
  // Address step
  function automatic logic [31:0] next_addr(input logic [31:0] a,
                                            input logic        wrap,
                                            input logic [1:0]  wl);
    logic [31:0] m;
    m = {24'h00_0000, (WLEN_BASE << wl) - 8'h01};
    if (wrap) begin
      return (a & ~m) | ((a + 32'h0000_0001) & m);
    end
    return (a >= ARRAY_TOP) ? 32'h0000_0000 : a + 32'h0000_0001;
  endfunction : next_addr

  // ==================================================================
  // Frame decoder
  always_comb begin
    nxt_st = st_ff;
    // Serial clock is sampled as an ordinary input, so edges lag a cycle
    rise = bus.sclk & ~st_ff.sclk_q;
    fall = ~bus.sclk & st_ff.sclk_q;
    w4 = (st_ff.st == D_CMD) ? st_ff.four_line_command_mode : st_ff.quad;
    cnt_n = st_ff.cnt + (w4 ? 6'h04 : 6'h01);
    shv = w4 ? {st_ff.sh[27:0], bus.io}
             : {st_ff.sh[30:0], bus.io[0]};
    abits = (st_ff.wrap && !i_addr4) ? ADDR3_BITS : ADDR4_BITS;
    ndum = !st_ff.wrap ? DUM_ENH
         : (st_ff.four_line_command_mode ? DUM_WRAP_4 : DUM_WRAP_1);
    bval = (st_ff.bitc == 3'h0) ? i_mem_data : st_ff.dbyte;
    nxt_st.sclk_q = bus.sclk;
    if (i_wlen_we) begin
      nxt_st.wlen = i_wlen;
    end
    if (bus.cs_n) begin
      // A frame cut before its mode byte ends is the exit frame; the
      // FFh opcode clocked on one line fills the address exactly
      if (st_ff.st == D_ADDR || st_ff.st == D_MODE) begin
        nxt_st.enh = 1'b0;
      end
      nxt_st.st = D_IDLE;
      nxt_st.oe_n = 4'hF;
    end else begin
      case (st_ff.st)
        D_IDLE: begin
          nxt_st.cnt = 6'h00;
          nxt_st.bitc = 3'h0;
          nxt_st.wrap = 1'b0;
          nxt_st.quad = st_ff.enh;
          nxt_st.st = st_ff.enh ? D_ADDR : D_CMD;
        end
        D_CMD: if (rise) begin
          nxt_st.sh = shv;
          nxt_st.cnt = cnt_n;
          if (cnt_n == OP_BITS) begin
            nxt_st.cnt = 6'h00;
            nxt_st.st = D_IGNORE;
            case (shv[7:0])
              OP_QIO4: begin
                // Busy or three-byte mode: the frame is dropped silently
                if (!i_busy && i_addr4) begin
                  nxt_st.st = D_ADDR;
                  nxt_st.quad = 1'b1;
                end
              end
              OP_WRAP: begin
                nxt_st.st = D_ADDR;
                nxt_st.quad = st_ff.four_line_command_mode;
                nxt_st.wrap = 1'b1;
              end
              OP_QPI_EN: nxt_st.four_line_command_mode = 1'b1;
              OP_ENH_RST: nxt_st.enh = 1'b0;
              default: nxt_st.st = D_IGNORE;
            endcase
          end
        end
        D_ADDR: if (rise) begin
          nxt_st.sh = shv;
          nxt_st.cnt = cnt_n;
          if (cnt_n == abits) begin
            nxt_st.cnt = 6'h00;
            nxt_st.addr = (abits == ADDR3_BITS)
                        ? {8'h00, shv[23:0]} : shv;
            nxt_st.st = st_ff.wrap ? D_DUMMY : D_MODE;
          end
        end
        D_MODE: if (rise) begin
          nxt_st.sh = shv;
          nxt_st.cnt = cnt_n;
          if (cnt_n == OP_BITS) begin
            nxt_st.cnt = 6'h00;
            nxt_st.enh = (shv[7:4] == ~shv[3:0]);
            nxt_st.st = D_DUMMY;
          end
        end
        D_DUMMY: if (rise) begin
          nxt_st.cnt = st_ff.cnt + 6'h01;
          if (st_ff.cnt[3:0] + 4'h1 == ndum) begin
            nxt_st.st = D_DATA;
          end
        end
        D_DATA: if (fall) begin
          if (st_ff.quad) begin
            nxt_st.dq = bval[7:4];
            nxt_st.oe_n = 4'h0;
            nxt_st.dbyte = {bval[3:0], 4'h0};
            nxt_st.bitc = st_ff.bitc + 3'h4;
          end else begin
            nxt_st.dq = {2'b00, bval[7], 1'b0};
            nxt_st.oe_n = 4'hD;
            nxt_st.dbyte = {bval[6:0], 1'b0};
            nxt_st.bitc = st_ff.bitc + 3'h1;
          end
          // Step the address on the last slice so the array has a
          // whole serial clock to settle the next byte
          if (st_ff.bitc == (st_ff.quad ? 3'h4 : 3'h7)) begin
            nxt_st.addr = next_addr(st_ff.addr, st_ff.wrap,
                                    st_ff.wlen);
          end
        end
        default: nxt_st.st = D_IGNORE;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      st_ff <= '0;
      st_ff.oe_n <= 4'hF;
      st_ff.wlen <= WLEN_RST;
    end else if (i_ce) begin
      st_ff <= nxt_st;
    end
  end

  assign bus.d_dq   = st_ff.dq;
  assign bus.d_oe_n = st_ff.oe_n;
  assign o_mem_addr = st_ff.addr;
  assign o_qpi      = st_ff.four_line_command_mode;
  assign o_enh      = st_ff.enh;
  assign o_wlen     = st_ff.wlen;
  assign o_active   = (st_ff.st == D_DATA);
endmodule : qrw_dev

// File: qrw_properties.sv
`timescale 1ns/1ps
// ====================================================================
// Link checks
module qrw_properties (
  input wire logic       i_clk_sys,
  input wire logic       i_nrst,
  input wire logic       i_cs_n,
  input wire logic       i_sclk,
  input wire logic [3:0] i_h_dq,
  input wire logic [3:0] i_h_oe_n,
  input wire logic [3:0] i_d_dq,
  input wire logic [3:0] i_d_oe_n
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);

  sequence s_open;
    $fell(i_cs_n);
  endsequence
  // Opcode alone takes far more than eight system clocks
  sequence s_dev_off;
    (i_d_oe_n == 4'hF)[*8];
  endsequence

  a_dev_late_start: assert property (s_open |-> s_dev_off)
    else $error("device drove during opcode");
  a_host_opens: assert property (s_open |-> i_h_oe_n != 4'hF)
    else $error("host silent at frame start");
  a_no_contention: assert property ((~i_d_oe_n & ~i_h_oe_n) == 4'h0)
    else $error("both ends drive the lines");
  a_dev_launch_low: assert property (
    i_d_oe_n != 4'hF && $changed(i_d_dq) |-> !i_sclk)
    else $error("device data moved while clock high");
  a_host_stable_rise: assert property (
    $rose(i_sclk) && i_h_oe_n != 4'hF |-> $stable(i_h_dq))
    else $error("host data moved at sampling edge");
  // High phase is fixed by HALF, which the bench leaves at 4
  a_sclk_high_len: assert property (
    $rose(i_sclk) |-> i_sclk[*4] ##1 !i_sclk)
    else $error("serial clock high phase wrong");
  a_cs_rise_sclk: assert property ($rose(i_cs_n) |-> !i_sclk)
    else $error("serial clock high at deselect");
  a_idle_sclk_low: assert property (
    i_cs_n && $past(i_cs_n) |-> !i_sclk)
    else $error("serial clock runs outside a frame");
  a_dev_release: assert property (
    $rose(i_cs_n) |-> ##[0:3] (i_d_oe_n == 4'hF))
    else $error("device kept lines after deselect");
  a_dev_quiet_idle: assert property (
    i_cs_n[*3] |-> i_d_oe_n == 4'hF)
    else $error("device drives while deselected");
endmodule : qrw_properties

// File: tb_quad_io_read_and_wrap_burst.sv
`timescale 1ns/1ps
// ====================================================================
// Both ends joined over the link, array modelled as address hash
module tb_quad_io_read_and_wrap_burst
  import qrw_pkg::*;
;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        start, addr4, busy_in, wlen_we, rx_ready;
  qrw_cmd_e    cmd;
  logic [31:0] addr;
  logic [7:0]  mode;
  logic [15:0] len;
  logic [1:0]  wlen;
  logic        h_busy, h_qpi, rx_valid, d_qpi, d_enh, enh, d_active;
  logic [7:0]  rx_data, mem_data;
  logic [31:0] mem_addr;
  logic [1:0]  d_wlen;
  logic [7:0]  rx_q[$];
  logic [7:0]  modes[8] = '{8'hA5, 8'h5A, 8'hF0, 8'h0F,
                            8'hFF, 8'h00, 8'hAA, 8'h55};
  int          failures = 0;
  int          total_checks = 0;

  qrw_if link ();

  always #12.5 clk = ~clk;

  function automatic logic [7:0] mem_f(input logic [31:0] a);
    return a[31:24] ^ a[23:16] ^ a[15:8] ^ a[7:0] ^ 8'h3C;
  endfunction : mem_f

  assign mem_data = mem_f(mem_addr);

  qrw_host #(.HALF(4), .FIFO_D(8)) u_qrw_host (
    .i_clk_sys(clk), .i_nrst(nrst), .i_ce(1'b1), .i_start(start),
    .i_cmd(cmd), .i_addr(addr), .i_mode(mode), .i_len(len),
    .i_addr4(addr4), .o_busy(h_busy), .o_qpi(h_qpi),
    .o_rx_valid(rx_valid), .o_rx_data(rx_data),
    .i_rx_ready(rx_ready), .bus(link));

  qrw_dev u_qrw_dev (
    .i_clk_sys(clk), .i_nrst(nrst), .i_ce(1'b1), .bus(link),
    .i_addr4(addr4), .i_busy(busy_in), .i_wlen_we(wlen_we),
    .i_wlen(wlen), .i_mem_data(mem_data), .o_mem_addr(mem_addr),
    .o_qpi(d_qpi), .o_enh(d_enh), .o_wlen(d_wlen),
    .o_active(d_active));

  qrw_properties u_qrw_properties (
    .i_clk_sys(clk), .i_nrst(nrst), .i_cs_n(link.cs_n),
    .i_sclk(link.sclk), .i_h_dq(link.h_dq), .i_h_oe_n(link.h_oe_n),
    .i_d_dq(link.d_dq), .i_d_oe_n(link.d_oe_n));

  // Taken at the edge itself, which is where the FIFO pops
  always @(posedge clk) begin
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      rx_q.push_back(rx_data);
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic complete_run();
    if (failures == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run

  // wl: -1 linear read, 0..3 wrap code, -2 device must stay silent
  task automatic run(input qrw_cmd_e c, input logic [31:0] a,
                     input logic [7:0] m, input int n, input int wl,
                     input int stall);
    int          k;
    int          w;
    logic [31:0] e;
    rx_q.delete();
    @(negedge clk);
    start = 1'b1;
    cmd = c;
    addr = a;
    mode = m;
    len = n[15:0];
    rx_ready = (stall == 0);
    @(negedge clk);
    start = 1'b0;
    repeat (stall) @(negedge clk);
    if (stall > 0) chk({h_busy, rx_valid, d_active}, 32'h7);
    rx_ready = 1'b1;
    k = 0;
    while ((h_busy !== 1'b0 || rx_valid !== 1'b0) && k < 20000) begin
      @(negedge clk);
      k++;
    end
    if (k >= 20000) begin
      failures++;
      $display("mismatch at %0t: transfer did not finish", $time);
    end
    chk(d_active, 0);
    chk(rx_q.size(), n);
    w = 8 << wl;
    for (int i = 0; i < n && i < rx_q.size(); i++) begin
      e = a + i;
      if (e > ARRAY_TOP_DEF) e = e - ARRAY_TOP_DEF - 1;
      if (wl >= 0) e = (a & ~(w - 1)) | ((a + i) & (w - 1));
      chk(rx_q[i], wl < -1 ? 8'hFF : mem_f(e));
    end
  endtask : run

  initial begin
    {start, addr4, busy_in, wlen_we, rx_ready} = '0;
    cmd = CMD_QIO;
    addr = '0;
    mode = '0;
    len = '0;
    wlen = '0;
    enh = 1'b0;
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    chk({link.cs_n, link.sclk, h_qpi, d_qpi, d_enh, d_wlen}, 32'h40);
    addr4 = 1'b1;
    run(CMD_QIO, 32'h01FF_FFFE, 8'hFF, 4, -1, 0);
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 8; k++) begin
        run(enh ? CMD_QIO_CONT : CMD_QIO, 32'h0100_0043 + k * 16,
            modes[k], 3, -1, 0);
        enh = (modes[k][7:4] == ~modes[k][3:0]);
        chk(d_enh, enh);
      end
      for (int w = 0; w < 4; w++) begin
        @(negedge clk);
        wlen_we = 1'b1;
        wlen = w[1:0];
        @(negedge clk);
        wlen_we = 1'b0;
        @(negedge clk);
        chk(d_wlen, w);
        addr4 = w[0];
        run(CMD_WRAP, {7'h00, w[0], 16'h1234, p ? 8'h3E : 8'h06},
            8'h00, (8 << w) + 3, w, w == 3 ? 1000 : 0);
      end
      addr4 = 1'b1;
      run(CMD_QIO, 32'h0000_0010, 8'hA5, 1, -1, 0);
      run(CMD_ENH_RST, 32'h0, 8'h00, 0, -1, 0);
      chk(d_enh, 0);
      busy_in = 1'b1;
      run(CMD_QIO, 32'h0000_0020, 8'hA5, 2, -2, 0);
      chk(d_enh, 0);
      busy_in = 1'b0;
      addr4 = 1'b0;
      run(CMD_QIO, 32'h0000_0030, 8'hFF, 2, -2, 0);
      addr4 = 1'b1;
      if (p == 0) begin
        run(CMD_QPI_EN, 32'h0, 8'h00, 0, -1, 0);
        chk({h_qpi, d_qpi}, 32'h3);
      end
    end
    complete_run();
  end

  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    complete_run();
  end
endmodule : tb_quad_io_read_and_wrap_burst
